// ---- adcseq_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcseq_checker #(
  parameter int NBITS = 8,
  parameter int NPINS = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic result_wr,
  input wire logic int_enable,
  input wire logic sleep,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_analog,
  input wire logic [7:0] converter_control_reg,
  input wire logic [NBITS-1:0] conv_result_reg,
  input wire logic [NPINS-1:0] port_read_reg,
  input wire logic conv_done_flag,
  input wire logic wake_reg,
  input wire logic powered_reg,
  input wire logic acquiring_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // Control, result and power relations
  chk_rsvd_zero: assert property (converter_control_reg[1] == 1'h0)
    else $error("reserved control bit reads back set");
  // Port readback lags one cycle, so only check once past reset
  chk_port_mask: assert property (!$past(rst) |-> port_read_reg == ($past(pin_in) & ~$past(pin_analog)))
    else $error("analog pin not read as low");
  chk_done_go: assert property ($rose(conv_done_flag) |-> $fell(converter_control_reg[2]))
    else $error("done flag rose without go clearing");
  chk_result_hold: assert property (!$past(rst) && $changed(conv_result_reg)
    |-> $past(result_wr) || $fell(converter_control_reg[2]))
    else $error("result changed without completion or write");
  chk_abort_quiet: assert property (ctrl_wr && !ctrl_wdata[2] && converter_control_reg[2]
    |=> !converter_control_reg[2] && !$rose(conv_done_flag))
    else $error("abort did not stop the conversion");
  chk_sleep_osc: assert property ((sleep && converter_control_reg[7:6] != 2'h3) [*3] |-> !powered_reg)
    else $error("oscillator clock kept converter powered in sleep");
  chk_on_kept: assert property (sleep && !ctrl_wr && converter_control_reg[0] |=> converter_control_reg[0])
    else $error("on bit lost during sleep");
  chk_off_power: assert property (!converter_control_reg[0] [*2] |-> !powered_reg)
    else $error("converter powered while switched off");
  chk_wake_pulse: assert property (wake_reg |-> conv_done_flag && int_enable ##1 !wake_reg)
    else $error("wake pulse without completion");
  chk_gap_idle: assert property ($rose(conv_done_flag) |-> !acquiring_reg [*4])
    else $error("acquisition resumed before the gap");
  // Main scenarios reached
  cov_done: cover property ($rose(conv_done_flag));
  cov_wake: cover property (wake_reg);
  cov_abort: cover property (ctrl_wr && !ctrl_wdata[2] && converter_control_reg[2]);
endmodule
bind adcseq_top adcseq_checker #(.NBITS(NBITS), .NPINS(NPINS)) u_adcseq_checker (
  .clk(clk),
  .rst(rst),
  .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata),
  .result_wr(result_wr),
  .int_enable(int_enable),
  .sleep(sleep),
  .pin_in(pin_in),
  .pin_analog(pin_analog),
  .converter_control_reg(converter_control_reg),
  .conv_result_reg(conv_result_reg),
  .port_read_reg(port_read_reg),
  .conv_done_flag(conv_done_flag),
  .wake_reg(wake_reg),
  .powered_reg(powered_reg),
  .acquiring_reg(acquiring_reg)
);
`default_nettype wire

// ---- adcseq_consts.svh ----
`ifndef ADCSEQ_CONSTS_SVH
`define ADCSEQ_CONSTS_SVH
// =====================================================
// Control register layout
`define ADCSEQ_CKSEL_HI 7
`define ADCSEQ_CKSEL_LO 6
`define ADCSEQ_CHSEL_HI 5
`define ADCSEQ_CHSEL_LO 3
`define ADCSEQ_GO_BIT 2
`define ADCSEQ_RSVD_BIT 1
`define ADCSEQ_ON_BIT 0
`define ADCSEQ_CTRL_RESET 8'h00
// =====================================================
// Per-bit period in oscillator periods (clk stands for the oscillator)
`define ADCSEQ_DIV_OSC2 8'h02
`define ADCSEQ_DIV_OSC8 8'h08
`define ADCSEQ_DIV_OSC32 8'h20
// Minimum per-bit period in ns, and clock period in ns
`define ADCSEQ_TAD_MIN_NS 1600
`define ADCSEQ_CLK_NS 10
// =====================================================
// Conversion timing in half per-bit periods: 9.5 periods total
`define ADCSEQ_HALF_TOTAL 5'd19
`define ADCSEQ_HALF_PRE 5'd4
`define ADCSEQ_HALF_GAP 5'd4
// One instruction cycle is four oscillator periods
`define ADCSEQ_INSTR_CYCLES 8'h04
`define ADCSEQ_NBITS 8
`endif

// ---- adcseq_pkg.sv ----
`default_nettype none
package adcseq_pkg;
  // Conversion clock source choices
  typedef enum logic [1:0] {
    ADCSEQ_CK_OSC2 = 2'b00,
    ADCSEQ_CK_OSC8 = 2'b01,
    ADCSEQ_CK_OSC32 = 2'b10,
    ADCSEQ_CK_RC = 2'b11
  } adcseq_cksel_t;
  // Fields of the control register
  typedef struct packed {
    adcseq_cksel_t cksel;
    logic [2:0] chsel;
    logic go;
    logic rsvd;
    logic on;
  } adcseq_ctrl_t;
endpackage
`default_nettype wire

// ---- adcseq_sar.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_consts.svh"
// Successive approximation register with per-bit validity
module adcseq_sar #(
  parameter int NBITS = `ADCSEQ_NBITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic step,
  input wire logic cmp_high,
  input wire logic tad_short,
  output logic [NBITS-1:0] trial,
  output logic [NBITS-1:0] valid,
  output logic [$clog2(NBITS+1)-1:0] done_bits
);
  logic [NBITS-1:0] mask_reg;
  // =====================================================
  // Each step keeps or drops the trial bit, then tries the next
  always_ff @(posedge clk) begin
    if (rst) begin
      trial <= '0;
      mask_reg <= '0;
      valid <= '0;
      done_bits <= '0;
    end else if (start) begin
      mask_reg <= {1'b1, {(NBITS-1){1'b0}}};
      trial <= {1'b1, {(NBITS-1){1'b0}}};
      valid <= '0;
      done_bits <= '0;
    end else if (step && mask_reg != '0) begin
      trial <= (cmp_high ? trial : (trial & ~mask_reg)) | (mask_reg >> 1);
      mask_reg <= mask_reg >> 1;
      // Bits resolved on a too-short period are flagged invalid
      valid <= valid | (tad_short ? '0 : mask_reg);
      done_bits <= done_bits + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- adcseq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcseq_tb;
  typedef struct packed {
    logic [1:0] ck;
    logic cmp;
    int half;
  } adcseq_row_t;
  // ==========================================
  // Stimulus signals
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ctrl_wr = 1'h0, result_wr = 1'h0, flag_clr = 1'h0, int_enable = 1'h0;
  logic sleep = 1'h0, rc_clk_tick = 1'h0, cmp_high = 1'h0, woke = 1'h0;
  logic [7:0] ctrl_wdata = 8'h00, result_wdata = 8'h00;
  logic [5:0] pin_in = 6'h3F, pin_analog = 6'h15, pin_direction_bits = 6'h3E;
  logic [7:0] ctl, res, vld;
  logic [5:0] prd;
  logic flag, wake, pwr, samp, acq;
  logic [1:0] tc = 2'h0;
  int bad_count = 0, checks_done = 0, n;
  // Half per-bit period in clocks; the RC row follows the tick process below
  // only RC meets minimum
  adcseq_row_t rows [4] = '{'{2'h0, 1'h1, 1}, '{2'h1, 1'h0, 4}, '{2'h2, 1'h1, 16}, '{2'h3, 1'h1, 4}};
  adcseq_top u_adcseq_top (
    .clk(clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .result_wr(result_wr), .result_wdata(result_wdata), .flag_clr(flag_clr),
    .int_enable(int_enable), .sleep(sleep), .rc_clk_tick(rc_clk_tick), .cmp_high(cmp_high),
    .pin_in(pin_in), .pin_out(6'h00), .pin_direction_bits(pin_direction_bits), .pin_analog(pin_analog),
    .converter_control_reg(ctl), .conv_result_reg(res), .result_valid_reg(vld), .port_read_reg(prd),
    .conv_done_flag(flag), .wake_reg(wake), .powered_reg(pwr), .sample_digital_reg(samp), .acquiring_reg(acq)
  );
  initial begin
    forever #5 clk = ~clk;
  end
  // RC edge every 4 clocks; wake is a one-cycle pulse, so latch it until flag clear
  always @(posedge clk) begin
    tc <= tc + 2'h1;
    rc_clk_tick <= (tc == 2'h3);
    woke <= (woke | wake) & ~flag_clr;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    ctrl_wr <= 1'h1;
    ctrl_wdata <= d;
    @(posedge clk);
    ctrl_wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic clr_flag();
    flag_clr <= 1'h1;
    @(posedge clk);
    flag_clr <= 1'h0;
  endtask
  // Bounded wait: sel high waits for go to clear, low for acquisition to start
  task automatic wait_on(input logic sel);
    n = 0;
    while (sel ? ctl[2] === 1'h1 : acq !== 1'h1) begin
      @(posedge clk);
      n++;
      if (n > 3000) begin
        bad_count++;
        complete_run();
      end
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(ctl, 8'h00);
    chk({4'h0, flag, pwr, acq, wake}, 8'h00);
    wr(8'h06);
    chk(ctl, 8'h00);
    chk({2'h0, prd}, 8'h2A);
    $display("test reset done");
    foreach (rows[i]) begin
      cmp_high <= rows[i].cmp;
      wr({rows[i].ck, 6'h01});
      wait_on(1'h0);
      chk({7'h00, samp}, 8'h01);
      wr({rows[i].ck, 6'h05});
      wait_on(1'h1);
      chk(res, rows[i].cmp ? 8'hFF : 8'h00);
      chk({6'h00, flag, n + 2 >= 19 * rows[i].half}, 8'h03);
      chk({7'h00, n + 2 <= 24 * rows[i].half + 8}, 8'h01);
      chk(vld, rows[i].ck == 2'h3 ? 8'hFF : 8'h00);
      clr_flag();
    end
    $display("test table done");
    result_wr <= 1'h1;
    result_wdata <= 8'h5A;
    @(posedge clk);
    result_wr <= 1'h0;
    wr(8'h81);
    wait_on(1'h0);
    wr(8'h85);
    repeat (60) @(posedge clk);
    wr(8'h81);
    chk(ctl, 8'h81);
    wait_on(1'h0);
    chk({7'h00, n >= 64}, 8'h01);
    chk({res[7:1], flag}, 8'h5A);
    $display("test abort done");
    wr(8'h85);
    repeat (40) @(posedge clk);
    sleep <= 1'h1;
    repeat (400) @(posedge clk);
    chk({5'h00, pwr, flag, ctl[0]}, 8'h01);
    chk(res, 8'h5A);
    sleep <= 1'h0;
    wr(8'hC1);
    wait_on(1'h0);
    $display("test sleep abort done");
    int_enable <= 1'h1;
    wr(8'hC5);
    sleep <= 1'h1;
    wait_on(1'h1);
    repeat (3) @(posedge clk);
    chk({6'h00, woke, flag}, 8'h03);
    chk(res, 8'hFF);
    clr_flag();
    sleep <= 1'h0;
    int_enable <= 1'h0;
    wait_on(1'h0);
    wr(8'hC5);
    sleep <= 1'h1;
    wait_on(1'h1);
    repeat (3) @(posedge clk);
    chk({5'h00, woke, pwr, ctl[0]}, 8'h01);
    sleep <= 1'h0;
    $display("test sleep convert done");
    complete_run();
  end
endmodule
`default_nettype wire

// ---- adcseq_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_consts.svh"
// Half per-bit period tick: oscillator divider or RC source edge
module adcseq_tick (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] cksel,
  input wire logic rc_clk_tick,
  output logic half_tick
);
  logic [7:0] cnt_reg;
  logic [7:0] half_div;
  // =====================================================
  // Divider
  // per-bit period select
  always_comb begin
    unique case (cksel)
      2'b00: half_div = `ADCSEQ_DIV_OSC2 >> 1;
      2'b01: half_div = `ADCSEQ_DIV_OSC8 >> 1;
      2'b10: half_div = `ADCSEQ_DIV_OSC32 >> 1;
      2'b11: half_div = 8'h01;
    endcase
  end
  // Restarts whenever idle so every divider phase starts on a clean boundary; RC edges pass through unaligned
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_reg <= 8'h00;
      half_tick <= 1'b0;
    end else if (cksel == 2'b11) begin
      cnt_reg <= 8'h00;
      half_tick <= rc_clk_tick;
    end else if (cnt_reg + 8'h01 >= half_div) begin
      cnt_reg <= 8'h00;
      half_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      half_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- adcseq_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_consts.svh"
// Operation
// - Full 8-bit conversion lasts 9.5 per-bit periods.
// - Clock select 00/01/10 give 2/8/32 oscillator periods, 11 RC source.
// - Port reads return low on analog-configured pins.
// - Output-direction analog pin converts its own driven level.
// - Sequencing ignores channel select and direction bits.
// - Clearing go mid-conversion aborts at once.
// - Abort leaves the result register untouched.
// - After abort, wait two periods then start acquisition.
// - Acquisition time independent of resolution.
// - Bits resolved on a too-short period are marked invalid.
// - Two periods before first bit, then one period per bit for seven bits, half a period for the last.
// - Conversion during sleep only with RC source.
// - RC source delays start by one instruction cycle.
// - Completion clears go and loads the result.
// - Completion in sleep with interrupt enabled wakes the core.
// - Sleep completion without interrupt powers down, on bit kept.
// - Sleep with oscillator clock aborts and powers down, on bit kept.
// - Completion sets the converter done flag.
// - Control layout: clock 7-6, channel 5-3, go 2, reserved 1, on 0.
// - At least two periods after a conversion before next acquisition.
// - Converter off when on bit clear.
module adcseq_top #(
  parameter int NBITS = `ADCSEQ_NBITS,
  parameter int NPINS = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic result_wr,
  input wire logic [NBITS-1:0] result_wdata,
  input wire logic flag_clr,
  input wire logic int_enable,
  input wire logic sleep,
  input wire logic rc_clk_tick,
  input wire logic cmp_high,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_direction_bits,
  input wire logic [NPINS-1:0] pin_analog,
  output logic [7:0] converter_control_reg,
  output logic [NBITS-1:0] conv_result_reg,
  output logic [NBITS-1:0] result_valid_reg,
  output logic [NPINS-1:0] port_read_reg,
  output logic conv_done_flag,
  output logic wake_reg,
  output logic powered_reg,
  output logic sample_digital_reg,
  output logic acquiring_reg
);
  // =====================================================
  // Sequencer state and strobes
  typedef enum logic [2:0] {S_IDLE, S_DELAY, S_PRE, S_BITS, S_HALF, S_GAP} adcseq_state_t;
  adcseq_state_t state_reg;
  adcseq_pkg::adcseq_ctrl_t ctrl;
  localparam int TAD_MIN_CYC = (`ADCSEQ_TAD_MIN_NS + `ADCSEQ_CLK_NS - 1) / `ADCSEQ_CLK_NS;
  logic [4:0] half_cnt_reg;
  logic [7:0] delay_cnt_reg;
  logic run;
  logic half_tick;
  logic sar_start;
  logic sar_step;
  logic tad_short;
  logic abort;
  logic finish;
  logic sleep_kill;
  logic is_rc;
  logic [NBITS-1:0] trial;
  logic [NBITS-1:0] valid;
  logic [2:0] chan;
  logic [NBITS-1:0] lsb_mask;
  logic [NBITS-1:0] last_word;
  logic [NBITS-1:0] last_valid;

  // =====================================================
  // Field decode
  assign ctrl = adcseq_pkg::adcseq_ctrl_t'(converter_control_reg);
  assign is_rc = (ctrl.cksel == adcseq_pkg::ADCSEQ_CK_RC);
  assign chan = ctrl.chsel;
  assign abort = ctrl_wr && !ctrl_wdata[`ADCSEQ_GO_BIT] &&
                 (state_reg == S_DELAY || state_reg == S_PRE || state_reg == S_BITS || state_reg == S_HALF);
  // sleep on oscillator clock kills conversion
  assign sleep_kill = sleep && !is_rc && state_reg != S_IDLE && state_reg != S_GAP;
  assign finish = (state_reg == S_HALF) && half_tick;
  // sequencing uses neither channel nor direction bits
  // Divider restarts on an abort, so the hold-off gets two whole periods on an oscillator clock; RC edges are not realigned
  assign run = powered_reg && (state_reg != S_IDLE) && !abort;
  assign sar_start = (state_reg == S_PRE) && half_tick && half_cnt_reg == `ADCSEQ_HALF_PRE - 5'd1;
  assign sar_step = (state_reg == S_BITS) && half_tick && half_cnt_reg[0];
  // Whole periods hold seven steps; the last bit is settled straight from the comparator
  assign lsb_mask = {{(NBITS-1){1'b0}}, 1'b1};
  assign last_word = cmp_high ? trial : (trial & ~lsb_mask);
  // At 100 MHz every oscillator setting is below the minimum; only RC gives valid bits
  // per-bit period below minimum
  assign tad_short = !is_rc && (32'(ctrl.cksel == 2'b00 ? `ADCSEQ_DIV_OSC2 :
                     ctrl.cksel == 2'b01 ? `ADCSEQ_DIV_OSC8 : `ADCSEQ_DIV_OSC32) < TAD_MIN_CYC);
  assign last_valid = valid | (tad_short ? '0 : lsb_mask);

  // =====================================================
  // Sub-blocks
  adcseq_tick u_tick (
    .clk(clk),
    .rst(rst),
    .run(run),
    .cksel(ctrl.cksel),
    .rc_clk_tick(rc_clk_tick),
    .half_tick(half_tick)
  );

  adcseq_sar #(.NBITS(NBITS)) u_sar (
    .clk(clk),
    .rst(rst),
    .start(sar_start),
    .step(sar_step),
    .cmp_high(cmp_high),
    .tad_short(tad_short),
    .trial(trial),
    .valid(valid),
    .done_bits()
  );

  // =====================================================
  // Control register
  // field layout, reserved bit held clear, reset to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      converter_control_reg <= `ADCSEQ_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        converter_control_reg <= ctrl_wdata & ~(8'h01 << `ADCSEQ_RSVD_BIT);
        // go ignored when written together with the enable
        if (!converter_control_reg[`ADCSEQ_ON_BIT]) begin
          converter_control_reg[`ADCSEQ_GO_BIT] <= 1'b0;
        end
        // Go written outside idle is refused, so a go write during the gap cannot leave it high
        if (state_reg != S_IDLE && !converter_control_reg[`ADCSEQ_GO_BIT]) begin
          converter_control_reg[`ADCSEQ_GO_BIT] <= 1'b0;
        end
      end
      if (finish || sleep_kill) begin
        converter_control_reg[`ADCSEQ_GO_BIT] <= 1'b0;
      end
    end
  end

  // =====================================================
  // Conversion sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      half_cnt_reg <= 5'd0;
      delay_cnt_reg <= 8'h00;
    end else if (!ctrl.on || sleep_kill) begin
      state_reg <= S_IDLE;
      half_cnt_reg <= 5'd0;
    end else if (abort) begin
      // Result and flag are left alone on this path
      // two-period wait then acquisition
      state_reg <= S_GAP;
      half_cnt_reg <= 5'd0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (ctrl_wr && ctrl_wdata[`ADCSEQ_GO_BIT] && ctrl.on) begin
            state_reg <= is_rc ? S_DELAY : S_PRE;
            delay_cnt_reg <= 8'h00;
            half_cnt_reg <= 5'd0;
          end
        end
        // RC start waits four clocks so the sleep instruction can land first
        S_DELAY: begin
          if (delay_cnt_reg == `ADCSEQ_INSTR_CYCLES - 8'h01) begin
            state_reg <= S_PRE;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 8'h01;
          end
        end
        S_PRE: begin
          if (half_tick) begin
            half_cnt_reg <= half_cnt_reg + 5'd1;
            if (half_cnt_reg == `ADCSEQ_HALF_PRE - 5'd1) begin
              state_reg <= S_BITS;
            end
          end
        end
        S_BITS: begin
          if (half_tick) begin
            half_cnt_reg <= half_cnt_reg + 5'd1;
            if (half_cnt_reg == `ADCSEQ_HALF_TOTAL - 5'd2) begin
              state_reg <= S_HALF;
            end
          end
        end
        // The last bit settles in this half period
        // final half period completes 9.5
        S_HALF: begin
          if (half_tick) begin
            state_reg <= S_GAP;
            half_cnt_reg <= 5'd0;
          end
        end
        // Entered from completion or abort, on a fresh divider phase except after an abort on the RC clock
        // two-period hold-off before acquisition
        S_GAP: begin
          if (half_tick) begin
            half_cnt_reg <= half_cnt_reg + 5'd1;
            if (half_cnt_reg == `ADCSEQ_HALF_GAP - 5'd1) begin
              state_reg <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // =====================================================
  // Result, validity and done flag
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_result_reg <= '0;
      result_valid_reg <= '0;
    end else if (finish && !abort && !sleep_kill) begin
      // load result; aborts never reach here
      conv_result_reg <= last_word;
      result_valid_reg <= last_valid;
    end else if (result_wr) begin
      conv_result_reg <= result_wdata;
      result_valid_reg <= '1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conv_done_flag <= 1'b0;
    end else if (finish && !abort && !sleep_kill) begin
      conv_done_flag <= 1'b1;
    end else if (flag_clr) begin
      conv_done_flag <= 1'b0;
    end
  end

  // =====================================================
  // Power and wake
  // Sleep keeps the converter powered only on the RC clock
  always_ff @(posedge clk) begin
    if (rst) begin
      powered_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      // Wake lasts one cycle; the core side latches it
      // wake on sleep completion with interrupt enabled
      wake_reg <= sleep && finish && int_enable;
      if (!ctrl.on) begin
        powered_reg <= 1'b0;
      end else if (sleep_kill || (sleep && !is_rc)) begin
        // oscillator clock cannot run in sleep
        powered_reg <= 1'b0;
      end else if (sleep && finish && !int_enable) begin
        powered_reg <= 1'b0;
      end else if (!sleep) begin
        // only RC keeps running across sleep
        powered_reg <= 1'b1;
      end
    end
  end

  // =====================================================
  // Pin side
  always_ff @(posedge clk) begin
    if (rst) begin
      port_read_reg <= '0;
      sample_digital_reg <= 1'b0;
      acquiring_reg <= 1'b0;
    end else begin
      port_read_reg <= pin_in & ~pin_analog;
      // Channels beyond the pin count convert no digital level
      // output pin converts its own driven level
      sample_digital_reg <= (32'(chan) < NPINS) ? !pin_direction_bits[chan] : 1'b0;
      acquiring_reg <= powered_reg && state_reg == S_IDLE;
    end
  end
endmodule
`default_nettype wire
